//--- bench/dcff_peer.sv
// Producer and consumer model driving both port clocks of the buffer.
// Assumes sys_clk samples the port clocks; strobes are held across each edge.
`timescale 1ns/1ps
module dcff_peer (
   input wire logic sys_clk,
   output logic write_clk,
   output logic write_en_n,
   output logic [dcff_pkg::DATA_W-1:0] write_data,
   output logic read_clk,
   output logic read_en_n,
   output logic reread_request_n
);
   import dcff_pkg::*;
   initial begin
      {write_clk, write_en_n, read_clk, read_en_n, reread_request_n} = 5'h0B;
      write_data = '0;
   end
   task automatic push(input logic [DATA_W-1:0] d);
      @(posedge sys_clk) write_clk <= 1'b0;
      @(posedge sys_clk) begin
         write_clk <= 1'b1;
         write_en_n <= 1'b0;
         write_data <= d;
      end
      // Stale data would hide a late sample, so invert it
      @(posedge sys_clk) begin
         write_en_n <= 1'b1;
         write_data <= ~d;
      end
   endtask : push
   task automatic pull(input logic ren_n, input logic rt_n);
      @(posedge sys_clk) read_clk <= 1'b0;
      @(posedge sys_clk) begin
         read_clk <= 1'b1;
         read_en_n <= ren_n;
         reread_request_n <= rt_n;
      end
      @(posedge sys_clk) begin
         read_en_n <= 1'b1;
         reread_request_n <= 1'b1;
      end
   endtask : pull
endmodule : dcff_peer

//--- bench/test_dual_clock_flagged_fifo.sv
// Self-checking bench for the flagged buffer: ports, resets, modes and registers.
// Assumes the peer model drives the port clocks and holds strobes across each edge.
`timescale 1ns/1ps
module test_dual_clock_flagged_fifo;
   import dcff_pkg::*;
   logic sys_clk, rst, master_reset_n, partial_reset_n, fall_through_serial_in_pin;
   logic offset_access_strobe_n, output_en_n, write_clk, write_en_n, read_clk, read_en_n;
   logic reread_request_n, read_data_oe, full_space_flag_n, empty_valid_flag_n;
   logic almost_full_flag_n, almost_empty_flag_n, half_full_flag_n, avs_read, avs_write;
   logic avs_waitrequest, serial_load_enable_n;
   logic [DATA_W-1:0] write_data, read_data;
   logic [AVS_AW-1:0] avs_address;
   logic [BUS_W-1:0] avs_writedata, avs_readdata, r, v;
   logic [DATA_W-1:0] q [4];
   int mismatches = 0;
   int comparisons = 0;
   int seed = 80814;
   int cycles = 0;
   dcff_top i_dcff_top (.sys_clk, .rst, .ce(1'b1), .master_reset_n, .partial_reset_n,
      .reread_request_n, .fall_through_serial_in_pin, .write_clk, .write_en_n, .write_data,
      .serial_load_enable_n, .offset_access_strobe_n, .read_clk, .read_en_n,
      .output_en_n, .read_data, .read_data_oe, .full_space_flag_n, .empty_valid_flag_n,
      .almost_full_flag_n, .almost_empty_flag_n, .half_full_flag_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
   dcff_peer i_dcff_peer (.sys_clk, .write_clk, .write_en_n, .write_data, .read_clk,
      .read_en_n, .reread_request_n);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic settle;
      repeat (4) @(negedge sys_clk);
   endtask : settle
   // Request stands until waitrequest is sampled low at a rising edge; data is taken there
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk) {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
      r = avs_readdata;
      {avs_write, avs_read} <= 2'b00;
   endtask : bus
   task automatic mreset(input logic ft, input logic ld);
      @(posedge sys_clk) {master_reset_n, fall_through_serial_in_pin, offset_access_strobe_n}
         <= {1'b0, ft, ld};
      repeat (2) @(posedge sys_clk);
      {master_reset_n, offset_access_strobe_n} <= 2'b11;
      settle;
   endtask : mreset
   function automatic logic [31:0] dflt(input logic ld);
      return ld ? 32'h000003FF : 32'h0000007F;
   endfunction : dflt
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test;
      end
   end
   initial begin
      {rst, master_reset_n, partial_reset_n, fall_through_serial_in_pin} = 4'hF;
      {offset_access_strobe_n, output_en_n, avs_read, avs_write} = 4'hC;
      serial_load_enable_n = 1'b1;
      avs_address = '0;
      avs_writedata = '0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      settle;
      check({read_data, read_data_oe, half_full_flag_n}, 11'h001);
      for (int k = 0; k < 2; k++) begin
         mreset(k[0], k[0]);
         bus(1'b0, REG_CFG, 0);
         check(r[1:0], {k[0], k[0]});
         bus(1'b0, REG_EOFS, 0);
         check(r, dflt(k[0]));
         bus(1'b0, REG_FOFS, 0);
         check(r, dflt(k[0]));
      end
      q[0] = 9'($random(seed));
      i_dcff_peer.push(q[0]);
      settle;
      repeat (3) i_dcff_peer.pull(1'b1, 1'b1);
      settle;
      check({read_data, empty_valid_flag_n, full_space_flag_n}, {q[0], 2'b00});
      mreset(1'b0, 1'b0);
      for (int i = 0; i < 4; i++) begin
         q[i] = 9'($random(seed));
         i_dcff_peer.push(q[i]);
      end
      settle;
      check({read_data, empty_valid_flag_n, full_space_flag_n}, 11'h003);
      bus(1'b0, REG_COUNT, 0);
      check(r, 4);
      for (int i = 0; i < 4; i++) begin
         i_dcff_peer.pull(1'b0, 1'b1);
         settle;
         check(read_data, q[i]);
      end
      check(empty_valid_flag_n, 1'b0);
      i_dcff_peer.pull(1'b1, 1'b0);
      i_dcff_peer.pull(1'b1, 1'b1);
      i_dcff_peer.pull(1'b0, 1'b1);
      settle;
      check(read_data, q[0]);
      v = 32'($random(seed)) & 32'h3FFF;
      bus(1'b1, REG_EOFS, v);
      @(posedge sys_clk) partial_reset_n <= 1'b0;
      @(posedge sys_clk) partial_reset_n <= 1'b1;
      settle;
      check(almost_empty_flag_n, v == 0);
      check({almost_full_flag_n, half_full_flag_n}, 2'b11);
      bus(1'b0, REG_EOFS, 0);
      check(r, v);
      bus(1'b0, REG_COUNT, 0);
      check(r, 0);
      bus(1'b1, 4'h6, 32'h1);
      bus(1'b0, 4'h2, 0);
      check(r, 0);
      // Serial method: 28 bits, empty offset first, then read one offset word back
      mreset(1'b0, 1'b1);
      {offset_access_strobe_n, serial_load_enable_n} <= 2'b00;
      v = 32'($random(seed));
      for (int i = 0; i < 28; i++) begin
         fall_through_serial_in_pin <= v[i];
         i_dcff_peer.push(9'h000);
      end
      i_dcff_peer.pull(1'b0, 1'b1);
      {offset_access_strobe_n, serial_load_enable_n} <= 2'b11;
      settle;
      check(read_data, v[8:0]);
      bus(1'b0, REG_EOFS, 0);
      check(r, v & 32'h3FFF);
      bus(1'b0, REG_FOFS, 0);
      check(r, (v >> 14) & 32'h3FFF);
      @(posedge sys_clk) output_en_n <= 1'b0;
      settle;
      check(read_data_oe, 1'b1);
      end_of_test;
   end
endmodule : test_dual_clock_flagged_fifo

//--- core/dcff_if.sv
// Carriers between the buffer controller, its memory and its offset registers.
// Assumes all three modules run on the same system clock.
`timescale 1ns/1ps
interface dcff_mem_if;
   logic wr_en;
   logic [dcff_pkg::ADDR_W-1:0] wr_addr;
   logic [dcff_pkg::DATA_W-1:0] wr_data;
   logic rd_en;
   logic [dcff_pkg::ADDR_W-1:0] rd_addr;
   logic [dcff_pkg::DATA_W-1:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : dcff_mem_if

interface dcff_ofs_if;
   logic def_load;
   logic def_large;
   logic idx_clr;
   logic par_wr;
   logic [dcff_pkg::DATA_W-1:0] par_data;
   logic ser_wr;
   logic ser_bit;
   logic rd_adv;
   logic bus_wr_e;
   logic bus_wr_f;
   logic [dcff_pkg::OFS_W-1:0] bus_data;
   logic [dcff_pkg::OFS_W-1:0] empty_ofs;
   logic [dcff_pkg::OFS_W-1:0] full_ofs;
   logic [dcff_pkg::DATA_W-1:0] rd_word;
   modport ctrl (output def_load, def_large, idx_clr, par_wr, par_data, ser_wr, ser_bit,
      rd_adv, bus_wr_e, bus_wr_f, bus_data, input empty_ofs, full_ofs, rd_word);
   modport regs (input def_load, def_large, idx_clr, par_wr, par_data, ser_wr, ser_bit,
      rd_adv, bus_wr_e, bus_wr_f, bus_data, output empty_ofs, full_ofs, rd_word);
endinterface : dcff_ofs_if

//--- core/dcff_mem.sv
// Word store of the buffer: one write port, one read port, registered read data.
// Assumes the controller never reads a location in the cycle it is written.
`timescale 1ns/1ps
module dcff_mem (
   input wire logic sys_clk,
   input wire logic ce,
   dcff_mem_if.store mem
);
   import dcff_pkg::*;
   logic [DATA_W-1:0] cells [0:DEPTH-1];
   logic [DATA_W-1:0] rd_q;

   // No reset on the array so it maps onto block RAM
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
         end
         if (mem.rd_en) begin
            rd_q <= cells[mem.rd_addr];
         end
      end
   end

   assign mem.rd_data = rd_q;
endmodule : dcff_mem

//--- core/dcff_ofs.sv
// Almost-empty and almost-full offset registers with serial, parallel and bus loading.
// Assumes the controller qualifies the parallel, serial and read strobes with the port clock edges.
`timescale 1ns/1ps
module dcff_ofs (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   dcff_ofs_if.regs ofs
);
   import dcff_pkg::*;
   logic [OFS_W-1:0] empty_ofs, next_empty_ofs;
   logic [OFS_W-1:0] full_ofs, next_full_ofs;
   logic [1:0] par_idx, next_par_idx;
   logic [1:0] rd_idx, next_rd_idx;
   logic [4:0] ser_cnt, next_ser_cnt;

   function automatic logic [DATA_W-1:0] ofs_word(input logic [1:0] idx,
         input logic [OFS_W-1:0] e, input logic [OFS_W-1:0] f);
      if (idx == PIDX_E_LO) ofs_word = e[DATA_W-1:0];
      else if (idx == PIDX_E_HI) ofs_word = DATA_W'(e[OFS_W-1:DATA_W]);
      else if (idx == PIDX_F_LO) ofs_word = f[DATA_W-1:0];
      else ofs_word = DATA_W'(f[OFS_W-1:DATA_W]);
   endfunction : ofs_word

   always_comb begin
      next_empty_ofs = empty_ofs;
      next_full_ofs = full_ofs;
      next_par_idx = par_idx;
      next_rd_idx = ofs.rd_adv ? rd_idx + 2'h1 : rd_idx;
      next_ser_cnt = ser_cnt;
      if (ofs.def_load) begin
         next_empty_ofs = ofs.def_large ? OFS_LARGE : OFS_SMALL;
         next_full_ofs = ofs.def_large ? OFS_LARGE : OFS_SMALL;
      end else if (ofs.bus_wr_e || ofs.bus_wr_f) begin
         if (ofs.bus_wr_e) next_empty_ofs = ofs.bus_data;
         if (ofs.bus_wr_f) next_full_ofs = ofs.bus_data;
      end else if (ofs.par_wr) begin
         next_par_idx = par_idx + 2'h1;
         if (par_idx == PIDX_E_LO) next_empty_ofs[DATA_W-1:0] = ofs.par_data;
         else if (par_idx == PIDX_E_HI) begin
            next_empty_ofs[OFS_W-1:DATA_W] = ofs.par_data[OFS_W-DATA_W-1:0];
         end
         else if (par_idx == PIDX_F_LO) next_full_ofs[DATA_W-1:0] = ofs.par_data;
         else next_full_ofs[OFS_W-1:DATA_W] = ofs.par_data[OFS_W-DATA_W-1:0];
      end else if (ofs.ser_wr) begin
         next_ser_cnt = (ser_cnt == SER_LAST) ? 5'h00 : ser_cnt + 5'h01;
         if (ser_cnt < SER_SPLIT) next_empty_ofs[ser_cnt[3:0]] = ofs.ser_bit;
         else next_full_ofs[4'(ser_cnt - SER_SPLIT)] = ofs.ser_bit;
      end
      if (ofs.idx_clr) begin
         next_par_idx = PIDX_E_LO;
         next_rd_idx = PIDX_E_LO;
         next_ser_cnt = 5'h00;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         empty_ofs <= OFS_SMALL;
         full_ofs <= OFS_SMALL;
         par_idx <= PIDX_E_LO;
         rd_idx <= PIDX_E_LO;
         ser_cnt <= 5'h00;
      end else if (ce) begin
         empty_ofs <= next_empty_ofs;
         full_ofs <= next_full_ofs;
         par_idx <= next_par_idx;
         rd_idx <= next_rd_idx;
         ser_cnt <= next_ser_cnt;
      end
   end

   assign ofs.empty_ofs = empty_ofs;
   assign ofs.full_ofs = full_ofs;
   assign ofs.rd_word = ofs_word(rd_idx, empty_ofs, full_ofs);

   property p_def_offset;
      @(posedge sys_clk) disable iff (rst)
      (ce && ofs.def_load) |=> (full_ofs == ($past(ofs.def_large) ? OFS_LARGE : OFS_SMALL));
   endproperty
   a_def_offset: assert property (p_def_offset) else $error("default offset wrong");
   property p_ser_first;
      @(posedge sys_clk) disable iff (rst)
      (ce && ofs.ser_wr && !ofs.def_load && !ofs.bus_wr_e && !ofs.bus_wr_f && !ofs.par_wr
         && !ofs.idx_clr && ser_cnt == 5'h00) |=> (empty_ofs[0] == $past(ofs.ser_bit)
         && ser_cnt == 5'h01);
   endproperty
   a_ser_first: assert property (p_ser_first) else $error("serial bit not shifted");
endmodule : dcff_ofs

//--- core/dcff_pkg.sv
// Constants, register map and types shared by the flagged buffer files.
// Assumes a single system clock; both port clocks arrive as sampled pins.
package dcff_pkg;
   localparam int DATA_W = 9;
   localparam int ADDR_W = 14;
   localparam int PTR_W = 15;
   localparam int OFS_W = 14;
   localparam int DEPTH = 16384;
   localparam int BUS_W = 32;
   localparam int AVS_AW = 4;
   localparam logic [PTR_W-1:0] DEPTH_CNT = 15'h4000;
   localparam logic [PTR_W-1:0] HALF_CNT = 15'h2000;
   localparam logic [OFS_W-1:0] OFS_SMALL = 14'h007F;
   localparam logic [OFS_W-1:0] OFS_LARGE = 14'h03FF;
   // Fall-through fetch happens on the third read clock edge
   localparam logic [1:0] FALL_LAST = 2'h2;
   // Serial loading: bits 0..13 empty offset, 14..27 full offset, LSB first
   localparam logic [4:0] SER_SPLIT = 5'h0E;
   localparam logic [4:0] SER_LAST = 5'h1B;
   localparam logic [1:0] PIDX_E_LO = 2'h0;
   localparam logic [1:0] PIDX_E_HI = 2'h1;
   localparam logic [1:0] PIDX_F_LO = 2'h2;
   localparam logic [1:0] PIDX_F_HI = 2'h3;
   // Flag reset order {full, empty, almost full, almost empty, half}
   localparam logic [4:0] FLAGS_RST = 5'h15;
   localparam logic [AVS_AW-1:0] REG_CFG = 4'h0;
   localparam logic [AVS_AW-1:0] REG_EOFS = 4'h4;
   localparam logic [AVS_AW-1:0] REG_FOFS = 4'h8;
   localparam logic [AVS_AW-1:0] REG_COUNT = 4'hC;
   localparam int ST_FALL_THROUGH_MODE = 0;
   localparam int ST_SER = 1;
   localparam int ST_EMPTY = 2;
   localparam int ST_FULL = 3;
   localparam int ST_HALF = 4;
   localparam int ST_AEMPTY = 5;
   localparam int ST_AFULL = 6;
   localparam int ST_VALID = 7;
   localparam int CTL_SOFT_PRS = 0;
   typedef enum logic [1:0] {OUT_EMPTY, OUT_FETCH, OUT_VALID} dcff_out_e;
endpackage : dcff_pkg

//--- core/dcff_top.sv
// Flagged first-in-first-out buffer of 9-bit words with offset flags and a register port.
// Assumes write and read port clocks are pins sampled by sys_clk, at most half its rate.
`timescale 1ns/1ps
// How it works
// - Master reset zeroes both pointers and clears the output data register.
// - While master reset is low, latch timing mode, default offsets and loading method.
// - Partial reset zeroes pointers but keeps mode, method and offset values.
// - Retransmit on a read edge rewinds the read pointer and forces empty briefly.
// - The shared pin picks timing mode during master reset, then feeds serial bits.
// - Enabled write edge stores a word, or an offset word under parallel loading.
// - Enabled serial load edge shifts one bit into the offset being programmed.
// - Enabled read edge delivers the next word, or an offset word when strobed.
// - Output enable decides whether the read data pins are driven.
// - Strobe level during master reset picks offset default and loading method.
// - After master reset the strobe steers enabled edges to the offset registers.
// - Full flag reports full in standard mode, space available in fall-through.
// - Empty flag reports empty in standard mode, valid output in fall-through.
// - Almost-full goes low when count exceeds capacity minus the full offset.
// - Almost-empty goes low when count is below the empty offset.
// - Half-full flag shows whether more than half the capacity is used.
// - Write data is nine bits and each write moves one nine-bit word.
// - Fall-through shows the first word after three read edges without read enable.
// - Standard mode shows a word only after an enabled read edge.
// - Strobe low gives offset 127 with parallel loading, else 1023 serial.
module dcff_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic master_reset_n,
   input wire logic partial_reset_n,
   input wire logic reread_request_n,
   input wire logic fall_through_serial_in_pin,
   input wire logic write_clk,
   input wire logic write_en_n,
   input wire logic [dcff_pkg::DATA_W-1:0] write_data,
   input wire logic serial_load_enable_n,
   input wire logic offset_access_strobe_n,
   input wire logic read_clk,
   input wire logic read_en_n,
   input wire logic output_en_n,
   output logic [dcff_pkg::DATA_W-1:0] read_data,
   output logic read_data_oe,
   output logic full_space_flag_n,
   output logic empty_valid_flag_n,
   output logic almost_full_flag_n,
   output logic almost_empty_flag_n,
   output logic half_full_flag_n,
   input wire logic [dcff_pkg::AVS_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [dcff_pkg::BUS_W-1:0] avs_writedata,
   output logic [dcff_pkg::BUS_W-1:0] avs_readdata,
   output logic avs_waitrequest
);
   import dcff_pkg::*;

   dcff_mem_if mem ();
   dcff_ofs_if ofs ();

   logic wr_clk_q, rd_clk_q;
   logic wr_edge, rd_edge;
   logic fall_through_mode, next_fall_through_mode;
   logic ser_mode, next_ser_mode;
   logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
   logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
   dcff_out_e out_st, next_out_st;
   logic [1:0] fall_cnt, next_fall_cnt;
   logic rt_busy, next_rt_busy;
   logic [DATA_W-1:0] next_read_data;
   logic [4:0] next_flags;
   logic next_oe;
   logic [BUS_W-1:0] next_readdata;
   logic next_waitrequest;
   logic [PTR_W-1:0] fill;
   logic empty, full, mr, pr, bus_acc, bus_prs;
   logic read_go, fall_go, fall_tick;

   function automatic logic [PTR_W-1:0] fill_of(input logic [PTR_W-1:0] wp,
         input logic [PTR_W-1:0] rp);
      fill_of = wp - rp;
   endfunction : fill_of

   dcff_mem u_mem (
      .sys_clk(sys_clk),
      .ce(ce),
      .mem(mem.store)
   );

   dcff_ofs u_ofs (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .ofs(ofs.regs)
   );

   // Both port sides live on sys_clk, so pointers compare directly without a crossing
   assign fill = fill_of(wr_ptr, rd_ptr);
   assign empty = (fill == '0);
   assign full = (fill == DEPTH_CNT);
   assign wr_edge = write_clk && !wr_clk_q;
   assign rd_edge = read_clk && !rd_clk_q;
   assign mr = !master_reset_n;
   assign bus_acc = avs_write && !avs_waitrequest;
   assign bus_prs = bus_acc && (avs_address == REG_CFG) && avs_writedata[CTL_SOFT_PRS];
   assign pr = !partial_reset_n || bus_prs;
   assign read_go = !read_en_n && (!fall_through_mode || out_st == OUT_VALID);
   assign fall_go = fall_through_mode && out_st == OUT_EMPTY && fall_cnt == FALL_LAST;
   assign fall_tick = fall_through_mode && out_st == OUT_EMPTY && !empty && !rt_busy;

   // Write side: data, offsets and the configuration caught at master reset
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_fall_through_mode = fall_through_mode;
      next_ser_mode = ser_mode;
      mem.wr_en = 1'h0;
      mem.wr_addr = wr_ptr[ADDR_W-1:0];
      mem.wr_data = write_data;
      ofs.par_wr = 1'h0;
      ofs.par_data = write_data;
      ofs.ser_wr = 1'h0;
      ofs.ser_bit = fall_through_serial_in_pin;
      ofs.def_load = mr;
      ofs.def_large = offset_access_strobe_n;
      ofs.idx_clr = mr || pr;
      if (mr) begin
         next_wr_ptr = '0;
         next_fall_through_mode = fall_through_serial_in_pin;
         next_ser_mode = offset_access_strobe_n;
      end else if (pr) begin
         next_wr_ptr = '0;
      end else if (wr_edge) begin
         if (!write_en_n && !offset_access_strobe_n) begin
            ofs.par_wr = !ser_mode;
         end else if (!write_en_n && !full) begin
            mem.wr_en = 1'h1;
            next_wr_ptr = wr_ptr + PTR_W'(1);
         end
         if (!serial_load_enable_n && !offset_access_strobe_n) begin
            ofs.ser_wr = ser_mode;
         end
      end
   end

   // Read side: output register, fall-through fetch and retransmit
   always_comb begin
      next_rd_ptr = rd_ptr;
      next_out_st = out_st;
      next_fall_cnt = fall_cnt;
      next_rt_busy = rt_busy;
      next_read_data = read_data;
      mem.rd_en = 1'h0;
      mem.rd_addr = rd_ptr[ADDR_W-1:0];
      ofs.rd_adv = 1'h0;
      // A fetch lands one cycle later; read_clk cannot rise again that soon
      if (out_st == OUT_FETCH) begin
         next_read_data = mem.rd_data;
         next_out_st = OUT_VALID;
      end
      if (mr) begin
         next_rd_ptr = '0;
         next_read_data = '0;
         next_out_st = OUT_EMPTY;
         next_fall_cnt = 2'h0;
         next_rt_busy = 1'h0;
      end else if (pr) begin
         next_rd_ptr = '0;
         next_out_st = OUT_EMPTY;
         next_fall_cnt = 2'h0;
         next_rt_busy = 1'h0;
      end else if (rd_edge) begin
         next_rt_busy = 1'h0;
         if (!reread_request_n) begin
            next_rd_ptr = '0;
            next_rt_busy = 1'h1;
            next_out_st = OUT_EMPTY;
            next_fall_cnt = 2'h0;
         end else if (!read_en_n && !offset_access_strobe_n) begin
            next_read_data = ofs.rd_word;
            ofs.rd_adv = 1'h1;
         end else if (!rt_busy && !empty && out_st != OUT_FETCH && (read_go || fall_go)) begin
            mem.rd_en = 1'h1;
            next_rd_ptr = rd_ptr + PTR_W'(1);
            next_out_st = OUT_FETCH;
            next_fall_cnt = 2'h0;
         end else if (fall_through_mode && !read_en_n && out_st == OUT_VALID) begin
            next_out_st = OUT_EMPTY;
         end else if (fall_tick) begin
            next_fall_cnt = fall_cnt + 2'h1;
         end
      end
   end

   // Flags and pin drivers, all registered
   always_comb begin
      next_flags[4] = fall_through_mode ? full : !full;
      next_flags[3] = fall_through_mode ? (out_st != OUT_VALID) : !(empty || rt_busy);
      next_flags[2] = !(fill > DEPTH_CNT - PTR_W'(ofs.full_ofs));
      next_flags[1] = !(fill < PTR_W'(ofs.empty_ofs));
      next_flags[0] = !(fill > HALF_CNT);
      next_oe = !output_en_n;
   end

   // Register port: one wait cycle, then the answer stands for one cycle
   always_comb begin
      next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
      next_readdata = avs_readdata;
      ofs.bus_wr_e = bus_acc && (avs_address == REG_EOFS);
      ofs.bus_wr_f = bus_acc && (avs_address == REG_FOFS);
      ofs.bus_data = avs_writedata[OFS_W-1:0];
      if (avs_read && avs_waitrequest) begin
         next_readdata = '0;
         if (avs_address == REG_CFG) begin
            next_readdata[ST_FALL_THROUGH_MODE] = fall_through_mode;
            next_readdata[ST_SER] = ser_mode;
            next_readdata[ST_EMPTY] = empty;
            next_readdata[ST_FULL] = full;
            next_readdata[ST_HALF] = !half_full_flag_n;
            next_readdata[ST_AEMPTY] = !almost_empty_flag_n;
            next_readdata[ST_AFULL] = !almost_full_flag_n;
            next_readdata[ST_VALID] = (out_st == OUT_VALID);
         end else if (avs_address == REG_EOFS) begin
            next_readdata = BUS_W'(ofs.empty_ofs);
         end else if (avs_address == REG_FOFS) begin
            next_readdata = BUS_W'(ofs.full_ofs);
         end else if (avs_address == REG_COUNT) begin
            next_readdata = BUS_W'(fill);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_clk_q <= 1'h0;
         rd_clk_q <= 1'h0;
         fall_through_mode <= 1'h0;
         ser_mode <= 1'h0;
         wr_ptr <= '0;
         rd_ptr <= '0;
         out_st <= OUT_EMPTY;
         fall_cnt <= 2'h0;
         rt_busy <= 1'h0;
         read_data <= '0;
      end else if (ce) begin
         wr_clk_q <= write_clk;
         rd_clk_q <= read_clk;
         fall_through_mode <= next_fall_through_mode;
         ser_mode <= next_ser_mode;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         out_st <= next_out_st;
         fall_cnt <= next_fall_cnt;
         rt_busy <= next_rt_busy;
         read_data <= next_read_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {full_space_flag_n, empty_valid_flag_n, almost_full_flag_n, almost_empty_flag_n,
            half_full_flag_n} <= FLAGS_RST;
         read_data_oe <= 1'h0;
         avs_waitrequest <= 1'h1;
         avs_readdata <= '0;
      end else if (ce) begin
         {full_space_flag_n, empty_valid_flag_n, almost_full_flag_n, almost_empty_flag_n,
            half_full_flag_n} <= next_flags;
         read_data_oe <= next_oe;
         avs_waitrequest <= next_waitrequest;
         avs_readdata <= next_readdata;
      end
   end

   property p_mrs_clear;
      @(posedge sys_clk) disable iff (rst)
      (ce && mr) |=> (read_data == '0 && wr_ptr == '0 && rd_ptr == '0);
   endproperty
   a_mrs_clear: assert property (p_mrs_clear) else $error("master reset did not clear");
   property p_mrs_config;
      @(posedge sys_clk) disable iff (rst)
      (ce && mr) |=> (fall_through_mode == $past(fall_through_serial_in_pin)
         && ser_mode == $past(offset_access_strobe_n));
   endproperty
   a_mrs_config: assert property (p_mrs_config) else $error("configuration not latched");
   property p_prs_keep;
      @(posedge sys_clk) disable iff (rst)
      (ce && !mr && pr) |=> (wr_ptr == '0 && rd_ptr == '0 && $stable(fall_through_mode)
         && $stable(ser_mode) && $stable(ofs.empty_ofs) && $stable(ofs.full_ofs));
   endproperty
   a_prs_keep: assert property (p_prs_keep) else $error("partial reset lost settings");
   property p_retransmit;
      @(posedge sys_clk) disable iff (rst)
      (ce && !mr && !pr && rd_edge && !wr_edge && !reread_request_n && !fall_through_mode) |=> (rd_ptr == '0
         && $stable(wr_ptr)) ##1 (!ce || !empty_valid_flag_n);
   endproperty
   a_retransmit: assert property (p_retransmit) else $error("retransmit misbehaved");
   property p_write_word;
      @(posedge sys_clk) disable iff (rst)
      (ce && !mr && !pr && wr_edge && !write_en_n && offset_access_strobe_n && !full)
         |=> (wr_ptr == $past(wr_ptr) + PTR_W'(1));
   endproperty
   a_write_word: assert property (p_write_word) else $error("write not stored");
   property p_oe;
      @(posedge sys_clk) disable iff (rst)
      ce |=> (read_data_oe == !$past(output_en_n));
   endproperty
   a_oe: assert property (p_oe) else $error("output enable not followed");
   property p_full_flag;
      @(posedge sys_clk) disable iff (rst)
      ce |=> (full_space_flag_n == ($past(fall_through_mode) ? $past(full) : !$past(full)));
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("full flag wrong for mode");
   property p_almost_full;
      @(posedge sys_clk) disable iff (rst)
      ce |=> (almost_full_flag_n == ($past(fill) <= DEPTH_CNT - PTR_W'($past(ofs.full_ofs))));
   endproperty
   a_almost_full: assert property (p_almost_full) else $error("almost full wrong");
   property p_almost_empty;
      @(posedge sys_clk) disable iff (rst)
      ce |=> (almost_empty_flag_n == ($past(fill) >= PTR_W'($past(ofs.empty_ofs))));
   endproperty
   a_almost_empty: assert property (p_almost_empty) else $error("almost empty wrong");
   property p_half;
      @(posedge sys_clk) disable iff (rst)
      ce |=> (half_full_flag_n == ($past(fill) <= HALF_CNT));
   endproperty
   a_half: assert property (p_half) else $error("half full wrong");
   property p_std_read;
      @(posedge sys_clk) disable iff (rst)
      (ce && !fall_through_mode && mem.rd_en) |-> (!read_en_n && rd_edge);
   endproperty
   a_std_read: assert property (p_std_read) else $error("standard fetch without read");
endmodule : dcff_top
